/* File: csb_host_model.sv */
// csb_host_model: network host side of the bank, sends message headers and reply requests
// assumes the bench calls its tasks from one process at a time, on the bank's clock
`timescale 1ns/1ps
module csb_host_model (
	input  wire logic       sys_clk,
	input  wire logic       msgAccept,
	input  wire logic       txStart,
	output logic            msgValid,
	output logic      [6:0] msgAddr,
	output logic            replyReq
);
	// idle values at time zero
	initial begin
		msgValid = 1'b0;
		msgAddr  = 7'h7f;
		replyReq = 1'b0;
	end
	// one header pulse; the filter answer is taken in the cycle after
	task automatic send_msg(input logic [6:0] a, output logic acc);
		@(posedge sys_clk);
		msgValid <= 1'b1;
		msgAddr  <= a;
		@(posedge sys_clk);
		msgValid <= 1'b0;
		msgAddr  <= ~a; // no stale address once the header is gone
		#1 acc = msgAccept;
	endtask : send_msg
	// reply request, then edges are counted until the send pulse, bounded
	task automatic reply(output int n);
		@(posedge sys_clk);
		replyReq <= 1'b1;
		@(posedge sys_clk);
		replyReq <= 1'b0;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while (txStart !== 1'b1 && n < 200);
	endtask : reply
endmodule : csb_host_model

/* File: csb_pkg.sv */
// csb_pkg: register map, field widths, defaults and timing of the controller settings bank
// assumes a 10 MHz system clock and a 32-bit plain register port with byte offsets
package csb_pkg;
	localparam int          CLK_HZ        = 10_000_000;
	localparam int          ADDR_W        = 8;
	// register byte offsets
	localparam logic [7:0]  OFS_PRG_ACC   = 8'h00;
	localparam logic [7:0]  OFS_TGT_ACC   = 8'h04;
	localparam logic [7:0]  OFS_FGN_ACC   = 8'h08;
	localparam logic [7:0]  OFS_PB_DEST   = 8'h0c;
	localparam logic [7:0]  OFS_SEC_CODE  = 8'h10;
	localparam logic [7:0]  OFS_MENU_EN   = 8'h14;
	localparam logic [7:0]  OFS_NET_ADDR  = 8'h18;
	localparam logic [7:0]  OFS_BAUD      = 8'h1c;
	localparam logic [7:0]  OFS_TURN      = 8'h20;
	localparam logic [7:0]  OFS_AN_DEST   = 8'h24;
	localparam logic [7:0]  OFS_AN_SRC    = 8'h28;
	localparam logic [7:0]  OFS_AN_MIN    = 8'h2c;
	localparam logic [7:0]  OFS_AN_MAX    = 8'h30;
	localparam logic [7:0]  OFS_OUT_RSV   = 8'h34;
	localparam logic [7:0]  OFS_OUT_SENSE = 8'h38;
	localparam logic [7:0]  OFS_OUT_SEL   = 8'h3c;
	localparam logic [7:0]  OFS_OUT_INV   = 8'h40;
	localparam logic [7:0]  OFS_STATUS    = 8'h44;
	localparam logic [7:0]  OFS_CONTROL   = 8'h48;
	// control bit positions
	localparam int          CTL_RESTART   = 0;
	localparam int          CTL_POWER     = 1;
	// access codes
	localparam logic [1:0]  ACC_LOCKED    = 2'h0;
	localparam logic [1:0]  ACC_FULL      = 2'h1;
	localparam logic [1:0]  ACC_CODE      = 2'h2;
	// reset values and limits
	localparam logic [1:0]  RST_ACC       = 2'h1;
	localparam logic [1:0]  RST_PB_DEST   = 2'h1;
	localparam logic [1:0]  MAX_PB_DEST   = 2'h3;
	localparam logic [13:0] RST_SEC_CODE  = 14'h0000;
	localparam logic [13:0] MAX_NUM       = 14'h270f;
	localparam logic [4:0]  RST_MENU_EN   = 5'h1f;
	localparam logic [6:0]  RST_NET_ADDR  = 7'h01;
	localparam logic [6:0]  MAX_NET_ADDR  = 7'h63;
	localparam logic [2:0]  RST_BAUD      = 3'h1;
	localparam logic [2:0]  MAX_BAUD      = 3'h5;
	localparam logic [5:0]  RST_TURN      = 6'h01;
	localparam logic [5:0]  MAX_TURN      = 6'h32;
	localparam logic [2:0]  RST_AN_DEST   = 3'h0;
	localparam logic [2:0]  MAX_AN_DEST   = 3'h6;
	localparam logic [1:0]  RST_AN_SRC    = 2'h1;
	localparam logic [1:0]  MAX_AN_SRC    = 2'h3;
	localparam logic [13:0] RST_AN_LIM    = 14'h0000;
	localparam logic [7:0]  RST_OUT_SW    = 8'h00;
	localparam logic        RST_SENSE     = 1'b0;
	localparam logic [31:0] RSV_VALUE     = 32'h00000001;
	// turnaround unit: 10 ms
	localparam int          TURN_UNIT_MS  = 10;
	localparam int          TURN_UNIT_CYC = CLK_HZ / 1000 * TURN_UNIT_MS;
	// bit periods at 300, 1200, 2400, 4800, 9600 baud
	localparam logic [15:0] BIT_CYC_300   = 16'(CLK_HZ / 300);
	localparam logic [15:0] BIT_CYC_1200  = 16'(CLK_HZ / 1200);
	localparam logic [15:0] BIT_CYC_2400  = 16'(CLK_HZ / 2400);
	localparam logic [15:0] BIT_CYC_4800  = 16'(CLK_HZ / 4800);
	localparam logic [15:0] BIT_CYC_9600  = 16'(CLK_HZ / 9600);
endpackage : csb_pkg

/* File: csb_settings_bank.sv */
// csb_settings_bank: settings store of a motor speed controller with the logic they steer
// assumes a same-clock register master and same-clock request pulses from panel and network logic
// Contract
// [R1] each of program, target and rate change has an access level: 0 locked, 1 free, 2 code needed, default 1.
// [R2] a new access level only acts after a controller restart; until then the old level holds.
// [R3] pushbutton default destination code 1 target, 2 program, 3 rate, default 1, overridable by the set menu.
// [R4] security code holds 0 to 9999, default 0, and zero turns all code checking off.
// [R5] the function-menu lockout is five switch bits, 0 to 31, default 31, one bit enabling each entry.
// [R6] network address holds 0 to 99, default 1, and at address 0 every incoming message is dropped.
// [R7] bit rate code 1 to 5 selects 300, 1200, 2400, 4800, 9600 baud, default 1.
// [R8] a changed bit rate code only acts after power is removed and reapplied.
// [R9] analog destination code 0 off, 1 target, 2 percent, 3 program, 4 rate, 5 main tach, 6 leader tach, default 0.
// [R10] analog source code 1 potentiometer, 2 zero to five volts, 3 current loop, default 1.
// [R11] analog input scales between minimum and maximum limits of 0 to 9999 each, default 0.
// [R12] output contact sense 0 normally open, 1 normally closed, default 0.
// [R13] two 8-bit switch sets, default 0, one selecting inputs of the output and one inverting inputs.
// [R14] a reply waits the turnaround delay, 1 to 50 units of 10 ms, default 1, before it is sent.
// [R15] the reserved output item is always written as 1 and stays at 1.
`timescale 1ns/1ps
module csb_settings_bank #(
	parameter int TURN_UNIT_CYC = csb_pkg::TURN_UNIT_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWrStb,
	input  wire logic        regRdStb,
	output logic      [31:0] regRdata,
	input  wire logic        chgReq,
	input  wire logic [1:0]  chgSel,
	input  wire logic [13:0] chgCode,
	output logic             chgGrant,
	output logic             chgDeny,
	output logic      [1:0]  pbDest,
	output logic      [4:0]  menuEnable,
	input  wire logic        msgValid,
	input  wire logic [6:0]  msgAddr,
	output logic             msgAccept,
	output logic      [15:0] bitCycles,
	input  wire logic        replyReq,
	output logic             txStart,
	output logic             txWaiting,
	output logic      [2:0]  analogDest,
	output logic      [1:0]  analogSrc,
	input  wire logic [9:0]  analogRaw,
	output logic      [13:0] analogValue,
	input  wire logic [7:0]  outInputs,
	output logic             outContact
);
	// stored settings
	logic [1:0]  accPrg_q, accTgt_q, accFgn_q, pbDest_q, anSrc_q;
	logic [13:0] secCode_q, anMin_q, anMax_q;
	logic [4:0]  menuEn_q;
	logic [6:0]  netAddr_q;
	logic [2:0]  baud_q, anDest_q;
	logic [5:0]  turn_q;
	logic        sense_q;
	logic [7:0]  outSel_q, outInv_q;
	// levels in force
	logic [1:0]  effPrg_q, effTgt_q, effFgn_q;
	logic [2:0]  effBaud_q;
	// turnaround timing
	logic [31:0] turnCyc_q;
	logic [5:0]  turnUnits_q;
	logic        ctlWr;

	// true when a write lands on the given offset with a value no larger than the limit
	function automatic logic fitsW(input logic [7:0] ofs, input logic [31:0] lim);
		return regWrStb && regAddr == ofs && regWdata <= lim;
	endfunction : fitsW

	// out-of-range values are dropped so a setting can never leave its documented span
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			accPrg_q  <= csb_pkg::RST_ACC;
			accTgt_q  <= csb_pkg::RST_ACC;
			accFgn_q  <= csb_pkg::RST_ACC;
			pbDest_q  <= csb_pkg::RST_PB_DEST;
			secCode_q <= csb_pkg::RST_SEC_CODE;
			menuEn_q  <= csb_pkg::RST_MENU_EN;
			netAddr_q <= csb_pkg::RST_NET_ADDR;
			baud_q    <= csb_pkg::RST_BAUD;
			turn_q    <= csb_pkg::RST_TURN;
			anDest_q  <= csb_pkg::RST_AN_DEST;
			anSrc_q   <= csb_pkg::RST_AN_SRC;
			anMin_q   <= csb_pkg::RST_AN_LIM;
			anMax_q   <= csb_pkg::RST_AN_LIM;
			sense_q   <= csb_pkg::RST_SENSE;
			outSel_q  <= csb_pkg::RST_OUT_SW;
			outInv_q  <= csb_pkg::RST_OUT_SW;
		end else begin
			if (fitsW(csb_pkg::OFS_PRG_ACC, 32'(csb_pkg::ACC_CODE))) accPrg_q <= regWdata[1:0]; // R1
			if (fitsW(csb_pkg::OFS_TGT_ACC, 32'(csb_pkg::ACC_CODE))) accTgt_q <= regWdata[1:0]; // R1
			if (fitsW(csb_pkg::OFS_FGN_ACC, 32'(csb_pkg::ACC_CODE))) accFgn_q <= regWdata[1:0]; // R1
			if (fitsW(csb_pkg::OFS_PB_DEST, 32'(csb_pkg::MAX_PB_DEST)) && regWdata != 32'h0)
				pbDest_q <= regWdata[1:0]; // R3
			if (fitsW(csb_pkg::OFS_SEC_CODE, 32'(csb_pkg::MAX_NUM))) secCode_q <= regWdata[13:0]; // R4
			if (fitsW(csb_pkg::OFS_MENU_EN, 32'(csb_pkg::RST_MENU_EN))) menuEn_q <= regWdata[4:0]; // R5
			if (fitsW(csb_pkg::OFS_NET_ADDR, 32'(csb_pkg::MAX_NET_ADDR))) netAddr_q <= regWdata[6:0]; // R6
			if (fitsW(csb_pkg::OFS_BAUD, 32'(csb_pkg::MAX_BAUD)) && regWdata != 32'h0)
				baud_q <= regWdata[2:0]; // R7
			if (fitsW(csb_pkg::OFS_TURN, 32'(csb_pkg::MAX_TURN)) && regWdata != 32'h0)
				turn_q <= regWdata[5:0]; // R14
			if (fitsW(csb_pkg::OFS_AN_DEST, 32'(csb_pkg::MAX_AN_DEST))) anDest_q <= regWdata[2:0]; // R9
			if (fitsW(csb_pkg::OFS_AN_SRC, 32'(csb_pkg::MAX_AN_SRC)) && regWdata != 32'h0)
				anSrc_q <= regWdata[1:0]; // R10
			if (fitsW(csb_pkg::OFS_AN_MIN, 32'(csb_pkg::MAX_NUM))) anMin_q <= regWdata[13:0]; // R11
			if (fitsW(csb_pkg::OFS_AN_MAX, 32'(csb_pkg::MAX_NUM))) anMax_q <= regWdata[13:0]; // R11
			if (fitsW(csb_pkg::OFS_OUT_SENSE, 32'h1)) sense_q <= regWdata[0]; // R12
			if (fitsW(csb_pkg::OFS_OUT_SEL, 32'hff)) outSel_q <= regWdata[7:0]; // R13
			if (fitsW(csb_pkg::OFS_OUT_INV, 32'hff)) outInv_q <= regWdata[7:0]; // R13
		end
	end

	assign ctlWr = regWrStb && regAddr == csb_pkg::OFS_CONTROL;

	// access levels move into force only on restart or power-up, never on the write itself
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			effPrg_q <= csb_pkg::RST_ACC;
			effTgt_q <= csb_pkg::RST_ACC;
			effFgn_q <= csb_pkg::RST_ACC;
		end else if (ctlWr && (regWdata[csb_pkg::CTL_RESTART] || regWdata[csb_pkg::CTL_POWER])) begin
			effPrg_q <= accPrg_q; // R2
			effTgt_q <= accTgt_q; // R2
			effFgn_q <= accFgn_q; // R2
		end
	end

	// the bit rate follows only a power cycle; a plain restart leaves the line rate alone
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			effBaud_q <= csb_pkg::RST_BAUD;
		else if (ctlWr && regWdata[csb_pkg::CTL_POWER])
			effBaud_q <= baud_q; // R8
	end

	// bit period of the rate in force
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			bitCycles <= csb_pkg::BIT_CYC_300;
		else begin
			unique case (effBaud_q) // R7
				3'h2:    bitCycles <= csb_pkg::BIT_CYC_1200;
				3'h3:    bitCycles <= csb_pkg::BIT_CYC_2400;
				3'h4:    bitCycles <= csb_pkg::BIT_CYC_4800;
				3'h5:    bitCycles <= csb_pkg::BIT_CYC_9600;
				default: bitCycles <= csb_pkg::BIT_CYC_300;
			endcase
		end
	end

	// change requests: chgSel 0 program, 1 target, 2 rate; code 3 is treated as locked
	logic [1:0] chgLvl;
	assign chgLvl = (chgSel == 2'h0) ? effPrg_q : (chgSel == 2'h1) ? effTgt_q : (chgSel == 2'h2) ? effFgn_q
	                : csb_pkg::ACC_LOCKED;
	logic chgOk;
	assign chgOk = chgLvl == csb_pkg::ACC_FULL // R1
	               || (chgLvl == csb_pkg::ACC_CODE && (secCode_q == 14'h0 || chgCode == secCode_q)); // R4
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			chgGrant <= 1'b0;
			chgDeny  <= 1'b0;
		end else begin
			chgGrant <= chgReq && chgOk;
			chgDeny  <= chgReq && !chgOk;
		end
	end

	// network filter: address zero drops everything
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			msgAccept <= 1'b0;
		else
			msgAccept <= msgValid && netAddr_q != 7'h0 && msgAddr == netAddr_q; // R6
	end

	// turnaround: units latched at request time so a later edit does not stretch a reply in flight
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			turnCyc_q   <= 32'h0;
			turnUnits_q <= 6'h0;
			txWaiting   <= 1'b0;
			txStart     <= 1'b0;
		end else begin
			txStart <= 1'b0;
			if (!txWaiting) begin
				if (replyReq) begin
					txWaiting   <= 1'b1;
					turnUnits_q <= turn_q; // R14
					turnCyc_q   <= 32'h0;
				end
			end else if (turnCyc_q == 32'(TURN_UNIT_CYC - 1)) begin
				turnCyc_q <= 32'h0;
				if (turnUnits_q == 6'h1) begin
					txWaiting <= 1'b0;
					txStart   <= 1'b1; // R14
				end
				turnUnits_q <= turnUnits_q - 6'h1;
			end else
				turnCyc_q <= turnCyc_q + 32'h1;
		end
	end

	// analog scaling: raw full scale maps onto min..max; max below min runs the slope downward
	logic [13:0] anSpan;
	logic [23:0] anProd;
	assign anSpan = (anMax_q >= anMin_q) ? anMax_q - anMin_q : anMin_q - anMax_q;
	assign anProd = anSpan * analogRaw;
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			analogValue <= csb_pkg::RST_AN_LIM;
		else if (anMax_q >= anMin_q)
			analogValue <= anMin_q + anProd[23:10]; // R11
		else
			analogValue <= anMin_q - anProd[23:10]; // R11
	end

	// user output: invert, select, any selected high closes the logic, sense flips the contact
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			outContact <= csb_pkg::RST_SENSE;
		else
			outContact <= (|((outInputs ^ outInv_q) & outSel_q)) ^ sense_q; // R12 R13
	end

	// plain setting outputs, registered copies
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pbDest     <= csb_pkg::RST_PB_DEST;
			menuEnable <= csb_pkg::RST_MENU_EN;
			analogDest <= csb_pkg::RST_AN_DEST;
			analogSrc  <= csb_pkg::RST_AN_SRC;
		end else begin
			pbDest     <= pbDest_q;   // R3
			menuEnable <= menuEn_q;   // R5
			analogDest <= anDest_q;   // R9
			analogSrc  <= anSrc_q;    // R10
		end
	end

	// read port: data in the cycle after the strobe only, unmapped offsets read zero
	always_ff @(posedge sys_clk) begin
		if (!reset_n || !regRdStb)
			regRdata <= 32'h0;
		else begin
			unique case (regAddr)
				csb_pkg::OFS_PRG_ACC:   regRdata <= 32'(accPrg_q);
				csb_pkg::OFS_TGT_ACC:   regRdata <= 32'(accTgt_q);
				csb_pkg::OFS_FGN_ACC:   regRdata <= 32'(accFgn_q);
				csb_pkg::OFS_PB_DEST:   regRdata <= 32'(pbDest_q);
				csb_pkg::OFS_SEC_CODE:  regRdata <= 32'(secCode_q);
				csb_pkg::OFS_MENU_EN:   regRdata <= 32'(menuEn_q);
				csb_pkg::OFS_NET_ADDR:  regRdata <= 32'(netAddr_q);
				csb_pkg::OFS_BAUD:      regRdata <= 32'(baud_q);
				csb_pkg::OFS_TURN:      regRdata <= 32'(turn_q);
				csb_pkg::OFS_AN_DEST:   regRdata <= 32'(anDest_q);
				csb_pkg::OFS_AN_SRC:    regRdata <= 32'(anSrc_q);
				csb_pkg::OFS_AN_MIN:    regRdata <= 32'(anMin_q);
				csb_pkg::OFS_AN_MAX:    regRdata <= 32'(anMax_q);
				csb_pkg::OFS_OUT_RSV:   regRdata <= csb_pkg::RSV_VALUE; // R15
				csb_pkg::OFS_OUT_SENSE: regRdata <= 32'(sense_q);
				csb_pkg::OFS_OUT_SEL:   regRdata <= 32'(outSel_q);
				csb_pkg::OFS_OUT_INV:   regRdata <= 32'(outInv_q);
				csb_pkg::OFS_STATUS:    regRdata <= {15'h0, txWaiting, 5'h0, effBaud_q, 2'h0, effFgn_q, effTgt_q, effPrg_q};
				default:                regRdata <= 32'h0;
			endcase
		end
	end

	// checks
	sequence accWrite_s;
		regWrStb && regAddr == csb_pkg::OFS_PRG_ACC && regWdata <= 32'h2 && !ctlWr;
	endsequence
	sequence replyTaken_s;
		replyReq && !txWaiting;
	endsequence

	prg_level_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R2
		accWrite_s |=> $stable(effPrg_q)) else $error("access level changed without restart");
	locked_denied_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R1
		chgReq && chgSel == 2'h0 && effPrg_q == 2'h0 |=> chgDeny && !chgGrant) else $error("locked change granted");
	free_granted_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R1
		chgReq && chgSel == 2'h1 && effTgt_q == 2'h1 |=> chgGrant) else $error("free change refused");
	code_bypass_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
		chgReq && chgLvl == 2'h2 && secCode_q == 14'h0 |=> chgGrant) else $error("zero code did not bypass");
	sec_range_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
		secCode_q <= csb_pkg::MAX_NUM) else $error("security code out of range");
	addr_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
		netAddr_q == 7'h0 |=> !msgAccept) else $error("message accepted at address zero");
	baud_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R8
		!(ctlWr && regWdata[csb_pkg::CTL_POWER]) |=> $stable(effBaud_q)) else $error("bit rate changed without power cycle");
	turn_min_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R14
		replyTaken_s |=> !txStart [*2]) else $error("reply sent before turnaround");
	out_logic_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R13
		outContact == ((|(($past(outInputs) ^ $past(outInv_q)) & $past(outSel_q))) ^ $past(sense_q)))
		else $error("contact does not follow switches");
	rsv_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
		regRdStb && regAddr == csb_pkg::OFS_OUT_RSV |=> regRdata == 32'h1) else $error("reserved item not 1");
	rd_once_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!$past(regRdStb) |-> regRdata == 32'h0) else $error("read data outside answer cycle");
endmodule : csb_settings_bank

/* File: tb_controller_settings_bank.sv */
// tb_controller_settings_bank: self-checking bench of the settings bank against a register mirror
// assumes csb_pkg and csb_host_model are compiled first
`timescale 1ns/1ps
module tb_controller_settings_bank;
	localparam int N = 4; // short turnaround unit keeps the run brief
	logic        sys_clk, reset_n, regWrStb, regRdStb, chgReq, chgGrant, chgDeny;
	logic        msgValid, msgAccept, replyReq, txStart, txWaiting, outContact;
	logic [7:0]  regAddr, outInputs;
	logic [31:0] regWdata, regRdata;
	logic [1:0]  chgSel, pbDest, analogSrc;
	logic [13:0] chgCode, analogValue;
	logic [4:0]  menuEnable;
	logic [6:0]  msgAddr;
	logic [15:0] bitCycles;
	logic [2:0]  analogDest;
	logic [9:0]  analogRaw;
	logic [31:0] seed = 32'hf74baa23;
	int          fail_count = 0;
	int          n_compared = 0;
	// mirror of the settings: legal range and current value per word
	int lo[17]  = '{0, 0, 0, 1, 0, 0, 0, 1, 1, 0, 1, 0, 0, 1, 0, 0, 0};
	int hi[17]  = '{2, 2, 2, 3, 9999, 31, 99, 5, 50, 6, 3, 9999, 9999, 1, 1, 255, 255};
	int mdl[17] = '{1, 1, 1, 1, 0, 31, 1, 1, 1, 0, 1, 0, 0, 1, 0, 0, 0};
	int rate[5] = '{300, 1200, 2400, 4800, 9600};

	csb_settings_bank #(.TURN_UNIT_CYC(N)) csb_settings_bank_inst (
		.sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdata(regRdata), .chgReq(chgReq),
		.chgSel(chgSel), .chgCode(chgCode), .chgGrant(chgGrant), .chgDeny(chgDeny),
		.pbDest(pbDest), .menuEnable(menuEnable), .msgValid(msgValid), .msgAddr(msgAddr),
		.msgAccept(msgAccept), .bitCycles(bitCycles), .replyReq(replyReq), .txStart(txStart),
		.txWaiting(txWaiting), .analogDest(analogDest), .analogSrc(analogSrc), .analogRaw(analogRaw),
		.analogValue(analogValue), .outInputs(outInputs), .outContact(outContact));
	csb_host_model host_inst (.sys_clk(sys_clk), .msgAccept(msgAccept), .txStart(txStart),
		.msgValid(msgValid), .msgAddr(msgAddr), .replyReq(replyReq));

	// lfsr step; value in 0..n-1
	function automatic int rnd(input int n);
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return int'(seed[30:0]) % n;
	endfunction : rnd
	// compare helpers, one per kind of result
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_bit(input logic got, input logic exp);
		chk_val({31'h0, got}, {31'h0, exp});
	endtask : chk_bit
	// register port: writes update the mirror only when the value is legal
	task automatic wr(input logic [7:0] a, input int d);
		@(posedge sys_clk);
		regWrStb <= 1'b1;
		regAddr  <= a;
		regWdata <= 32'(d);
		@(posedge sys_clk);
		regWrStb <= 1'b0;
		if (a < 8'h44 && a[1:0] == 2'h0 && d >= lo[a[7:2]] && d <= hi[a[7:2]]) mdl[a[7:2]] = d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		regRdStb <= 1'b1;
		regAddr  <= a;
		@(posedge sys_clk);
		regRdStb <= 1'b0;
		#1 v = regRdata;
	endtask : rd
	task automatic chk_reg(input logic [7:0] a);
		logic [31:0] v;
		rd(a, v);
		chk_val(v, (a < 8'h44) ? 32'(mdl[a[7:2]]) : 32'h0);
	endtask : chk_reg
	// change request; grant or deny is due one cycle later
	task automatic chg(input logic [1:0] s, input logic [13:0] c, input logic g);
		@(posedge sys_clk);
		chgReq  <= 1'b1;
		chgSel  <= s;
		chgCode <= c;
		@(posedge sys_clk);
		chgReq  <= 1'b0;
		#1 chk_bit(chgGrant, g);
		chk_bit(chgDeny, !g);
	endtask : chg
	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test

	// clock and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		finish_test();
	end
	// main sequence
	initial begin : main
		logic [31:0] v;
		logic        acc;
		int          n, mn, mx, raw;
		{reset_n, regWrStb, regRdStb, chgReq, chgSel, regAddr, regWdata} = '0;
		{chgCode, analogRaw, outInputs} = '0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		#1 chk_val(32'(bitCycles), 32'(csb_pkg::CLK_HZ / 300));
		// walk every word: default, refused values, then a random legal value
		for (int i = 0; i < 17; i++) begin
			chk_reg(8'(i * 4));
			// the reserved item is only ever written as 1, so it gets no refused values
			if (i != 13) wr(8'(i * 4), hi[i] + 1);
			if (lo[i] > 0 && i != 13) wr(8'(i * 4), lo[i] - 1);
			chk_reg(8'(i * 4));
			wr(8'(i * 4), lo[i] + rnd(hi[i] - lo[i] + 1));
			chk_reg(8'(i * 4));
		end
		chk_val(32'(pbDest), 32'(mdl[3]));
		chk_val(32'(menuEnable), 32'(mdl[5]));
		chk_val(32'(analogDest), 32'(mdl[9]));
		chk_val(32'(analogSrc), 32'(mdl[10]));
		// levels in force stay at reset values until a restart; status ignores writes
		wr(8'h44, 0);
		wr(8'h80, 5);
		chk_reg(8'h80);
		rd(8'h44, v);
		chk_val(v, 32'h00000115);
		$display("test register map done");
		// restart makes the new access levels act
		wr(8'h00, 0);
		wr(8'h04, 2);
		wr(8'h08, 2);
		wr(8'h10, 1234);
		chg(2'h0, 14'h0, 1'b1);
		wr(8'h48, 1);
		chg(2'h0, 14'h0, 1'b0);
		chg(2'h1, 14'h4d1, 1'b0);
		chg(2'h1, 14'h4d2, 1'b1);
		chg(2'h2, 14'h4d2, 1'b1);
		chg(2'h3, 14'h4d2, 1'b0);
		wr(8'h10, 0);
		chg(2'h2, 14'h37, 1'b1);
		$display("test access levels done");
		// message filter on own address and on address zero
		wr(8'h18, 7);
		host_inst.send_msg(7'h07, acc);
		chk_bit(acc, 1'b1);
		host_inst.send_msg(7'h01, acc);
		chk_bit(acc, 1'b0);
		wr(8'h18, 0);
		host_inst.send_msg(7'h00, acc);
		chk_bit(acc, 1'b0);
		$display("test message filter done");
		// bit rate acts only after a power cycle
		for (int i = 4; i >= 0; i--) begin
			v = 32'(bitCycles);
			wr(8'h1c, i + 1);
			repeat (2) @(posedge sys_clk);
			#1 chk_val(32'(bitCycles), v);
			wr(8'h48, 2);
			repeat (2) @(posedge sys_clk);
			#1 chk_val(32'(bitCycles), 32'(csb_pkg::CLK_HZ / rate[i]));
		end
		$display("test bit rate done");
		// turnaround at the short and a longer setting
		for (int u = 1; u <= 3; u += 2) begin
			wr(8'h20, u);
			// waiting flag looked at one edge after the request is taken, and again after the send pulse
			fork
				host_inst.reply(n);
				begin
					repeat (3) @(posedge sys_clk);
					#1 chk_bit(txWaiting, 1'b1);
				end
			join
			chk_val(32'(n), 32'(u * N));
			chk_bit(txWaiting, 1'b0);
			if (n >= 200) finish_test();
		end
		$display("test turnaround done");
		// analog scaling, full-scale sample first
		for (int i = 0; i < 4; i++) begin
			mn = rnd(10000);
			mx = rnd(10000);
			raw = (i == 0) ? 1023 : rnd(1024);
			wr(8'h2c, mn);
			wr(8'h30, mx);
			analogRaw <= 10'(raw);
			repeat (3) @(posedge sys_clk);
			n = (mx >= mn) ? mn + (((mx - mn) * raw) >> 10) : mn - (((mn - mx) * raw) >> 10);
			#1 chk_val(32'(analogValue), 32'(n));
		end
		$display("test analog scaling done");
		// output logic with random switches, inputs and sense
		for (int i = 0; i < 6; i++) begin
			wr(8'h3c, rnd(256));
			wr(8'h40, rnd(256));
			wr(8'h38, rnd(2));
			n = rnd(256);
			outInputs <= 8'(n);
			repeat (3) @(posedge sys_clk);
			#1 chk_bit(outContact, (((n ^ mdl[16]) & mdl[15]) != 0) ^ (mdl[14] == 1));
		end
		$display("test output logic done");
		finish_test();
	end
endmodule : tb_controller_settings_bank
